// >>> esqw_pkg.sv
// Package for the encoder square-wave output link.
// Shared by the encoder end and the receiver end; no bus, one clock.
package esqw_pkg;
	// Core clock rate and fault low-pulse minimum
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned FAULT_MIN_MS = 20;
	localparam int unsigned FAULT_MIN_CYC = (CLK_HZ / 1000) * FAULT_MIN_MS;
	// Counter and angle widths
	localparam int unsigned DIV_W = 16;
	localparam int unsigned FLT_W = 20;
	localparam int unsigned POS_W = 32;
	localparam int unsigned ANG_W = 12;
	// Commutation block counts per revolution
	localparam logic [1:0] COMM_2X180 = 2'h0;
	localparam logic [1:0] COMM_3X120 = 2'h1;
	localparam logic [1:0] COMM_4X90 = 2'h2;
	// Evaluation modes of the receiver
	localparam logic [1:0] EVAL_1X = 2'h0;
	localparam logic [1:0] EVAL_2X = 2'h1;
	localparam logic [1:0] EVAL_4X = 2'h2;
	// Quadrature steps per electrical period, less one
	localparam logic [1:0] QSTEPS = 2'h3;
endpackage

// >>> esqw_if.sv
// Interface joining the encoder end and the receiver end.
// Assumes both ends share core_clk_i; all lines are push-pull levels.
`timescale 1ns/1ps
interface esqw_if;
	logic quad_channel_a;
	logic quad_channel_a_n;
	logic quad_channel_b;
	logic quad_channel_b_n;
	logic ref_mark_pulse;
	logic ref_mark_pulse_n;
	logic fault_out_n;
	logic [2:0] comm;
	logic [2:0] comm_n;
	logic limit_out_first;
	logic limit_out_second;
	modport encoder (output quad_channel_a, quad_channel_a_n, quad_channel_b,
		quad_channel_b_n, ref_mark_pulse, ref_mark_pulse_n, fault_out_n, comm, comm_n,
		limit_out_first, limit_out_second);
	modport receiver (input quad_channel_a, quad_channel_a_n, quad_channel_b,
		quad_channel_b_n, ref_mark_pulse, ref_mark_pulse_n, fault_out_n, comm, comm_n,
		limit_out_first, limit_out_second);
endinterface

// >>> esqw_encoder.sv
// Encoder end: quadrature, reference, fault, commutation and limit outputs.
// Assumes synchronous user inputs; the receiver catches every edge.
// Function
// R01: A and B offset by 90 electrical degrees
// R02: Reference pulse gated to one quadrature state
// R03: Reference width is a quarter period
// R04: Complement outputs, omitted for single-ended variant; code holds A, B and Z complements low there, commutation ones driven
// R05: B lags A in reference direction
// R06: Fault low on malfunction, high otherwise; code also holds it low for the minimum after reset
// R07: Fault low pulse lasts at least 20 ms
// R08: Receiver measuring step from counted edges
// R09: Receiver counts every edge of A and B
// R10: Receiver resolves 90 percent edge spacing
// R11: Receiver may shut down on fault low
// R12: Three commutation waves plus complements
// R13: Commutation 2x180, 3x120 or 4x90 mechanical
// R14: Two static limit lines, no decoding
// R15: First limit north magnet, second south magnet
// R16: Magnet row holds limit across its span
// R17: Receiver syncs inputs, counts by phase order
// R18: Receiver flags simultaneous A and B change
`timescale 1ns/1ps
module esqw_encoder (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Motion control
	input wire logic move_en_i,
	input wire logic move_dir_i,
	input wire logic [esqw_pkg::DIV_W-1:0] step_div_i,
	input wire logic ref_here_i,
	input wire logic [esqw_pkg::ANG_W-1:0] angle_i,
	input wire logic [1:0] comm_mode_i,
	// Variant, fault and magnet sensing
	input wire logic single_ended_variant_i,
	input wire logic malfunction_i,
	input wire logic magnet_north_i,
	input wire logic magnet_south_i,
	// Link
	esqw_if.encoder link
);
	import esqw_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [1:0] phase;
		logic [FLT_W-1:0] flt_cnt;
		logic fault_n;
		logic a, an, b, bn, z, zn;
		logic [2:0] cm, cmn;
		logic l1, l2;
	} esqw_enc_t;

	esqw_enc_t st;
	esqw_enc_t nx;

	// Commutation track level for a given angle fraction and mode
	function automatic logic [2:0] esqw_comm(input logic [ANG_W-1:0] ang,
			input logic [1:0] mode);
		logic [ANG_W+1:0] s;
		logic [2:0] r;
		s = {2'h0, ang};
		r = 3'h0;
		case (mode)
			COMM_3X120: begin
				// Three 120 degree blocks, tracks shifted a third
				r[0] = (s * 14'h3) >> ANG_W == 14'h0;
				r[1] = (s * 14'h3) >> ANG_W == 14'h1;
				r[2] = (s * 14'h3) >> ANG_W == 14'h2;
			end
			COMM_4X90: begin
				r[0] = ang[ANG_W-1:ANG_W-2] == 2'h0;
				r[1] = ang[ANG_W-1:ANG_W-2] == 2'h1;
				r[2] = ang[ANG_W-1:ANG_W-2] == 2'h2;
			end
			default: begin
				// Two 180 degree blocks, third track a quarter later
				r[0] = ~ang[ANG_W-1];
				r[1] = ang[ANG_W-1];
				r[2] = ang[ANG_W-1] ^ ang[ANG_W-2];
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [1:0] ph;
		logic step;
		ph = st.phase;
		nx = st;
		step = 1'b0;
		// Step rate divider; one quadrature step per wrap
		if (move_en_i) begin
			if (st.div >= step_div_i) begin
				nx.div = '0;
				step = 1'b1;
			end else begin
				nx.div = st.div + 1'b1;
			end
		end else begin
			nx.div = '0;
		end
		// Gray sequence; direction picks phase order [R01] [R05]
		if (step) begin
			ph = move_dir_i ? st.phase - 2'h1 : st.phase + 2'h1;
		end
		nx.phase = ph;
		nx.a = ph[1] ^ ph[0]; // 0,1,1,0 over steps 0..3
		nx.b = ph[1]; // 0,0,1,1 lags A by one step [R01] [R05]
		// Reference only in state A high and B high, one quarter wide [R02] [R03]
		nx.z = ref_here_i & (ph == 2'h2);
		// Fault: holds low for the minimum even if malfunction clears [R06] [R07]
		if (malfunction_i) begin
			nx.fault_n = 1'b0;
			nx.flt_cnt = '0;
		end else if (!st.fault_n) begin
			if (st.flt_cnt >= FLT_W'(FAULT_MIN_CYC - 1)) begin
				nx.fault_n = 1'b1;
			end else begin
				nx.flt_cnt = st.flt_cnt + 1'b1;
			end
		end
		// Commutation waves from the angle tracks [R12] [R13]
		nx.cm = esqw_comm(angle_i, comm_mode_i);
		// Quadrature and reference complements held low on the single-ended variant; commutation complements always driven [R04] [R12]
		nx.an = single_ended_variant_i ? 1'b0 : ~nx.a;
		nx.bn = single_ended_variant_i ? 1'b0 : ~nx.b;
		nx.zn = single_ended_variant_i ? 1'b0 : ~nx.z;
		nx.cmn = ~nx.cm;
		// Static limits: north on first, south on second, level follows magnets [R14] [R15] [R16]
		nx.l1 = magnet_north_i;
		nx.l2 = magnet_south_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; fault reads low after reset until the minimum elapses
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	// Link outputs straight from flops
	assign link.quad_channel_a = st.a;
	assign link.quad_channel_a_n = st.an;
	assign link.quad_channel_b = st.b;
	assign link.quad_channel_b_n = st.bn;
	assign link.ref_mark_pulse = st.z;
	assign link.ref_mark_pulse_n = st.zn;
	assign link.fault_out_n = st.fault_n;
	assign link.comm = st.cm;
	assign link.comm_n = st.cmn;
	assign link.limit_out_first = st.l1;
	assign link.limit_out_second = st.l2;
endmodule

// >>> esqw_receiver.sv
// Receiver end: synchronises the link and counts position.
// Assumes the encoder meets the edge spacing this clock can resolve.
`timescale 1ns/1ps
module esqw_receiver (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Configuration
	input wire logic [1:0] eval_mode_i,
	// Link
	esqw_if.receiver link,
	// User side
	output logic [esqw_pkg::POS_W-1:0] position_o,
	output logic ref_seen_o,
	output logic fault_o,
	output logic shutdown_o,
	output logic step_err_o,
	output logic [2:0] comm_o,
	output logic limit_first_o,
	output logic limit_second_o
);
	import esqw_pkg::*;

	typedef struct packed {
		logic [3:0] s1, s2; // a, b, z, fault_n
		logic [1:0] prev;
		logic [POS_W-1:0] pos;
		logic ref_seen, fault, shut, err;
		logic [2:0] cm;
		logic l1, l2;
	} esqw_rx_t;

	esqw_rx_t st;
	esqw_rx_t nx;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and count
	always_comb begin
		logic a, b, da, db, up, cnt;
		nx = st;
		// Two-stage synchroniser; s1 feeds only s2 [R17]
		nx.s1 = {link.quad_channel_a, link.quad_channel_b, link.ref_mark_pulse,
			link.fault_out_n};
		nx.s2 = st.s1;
		a = st.s2[3];
		b = st.s2[2];
		da = a ^ st.prev[1];
		db = b ^ st.prev[0];
		nx.prev = {a, b};
		// Direction from phase order: B lagging A counts up [R17]
		up = da ? (a ^ b) : ~(a ^ b);
		// Edge qualifying per evaluation mode [R08] [R09]
		case (eval_mode_i)
			EVAL_1X: cnt = da & a & ~b | da & ~a & ~b;
			EVAL_2X: cnt = da;
			default: cnt = da | db;
		endcase
		if (da & db) begin
			// Both changed in one sample: unresolved step, sticky [R18] [R10]
			nx.err = 1'b1;
		end else if (cnt) begin
			nx.pos = up ? st.pos + 1'b1 : st.pos - 1'b1;
		end
		// Reference seen while gated quadrature state holds
		if (st.s2[1] & a & b) begin
			nx.ref_seen = 1'b1;
		end
		// Fault low drives shutdown request [R11]
		nx.fault = ~st.s2[0];
		nx.shut = st.shut | ~st.s2[0];
		nx.cm = link.comm;
		nx.l1 = link.limit_out_first;
		nx.l2 = link.limit_out_second;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign position_o = st.pos;
	assign ref_seen_o = st.ref_seen;
	assign fault_o = st.fault;
	assign shutdown_o = st.shut;
	assign step_err_o = st.err;
	assign comm_o = st.cm;
	assign limit_first_o = st.l1;
	assign limit_second_o = st.l2;
endmodule

// >>> esqw_link_asserts.sv
// Checker for the encoder link, watching the interface lines.
// Assumes one clock and an async high reset shared by both ends.
`timescale 1ns/1ps
module esqw_link_asserts (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Encoder inputs
	input wire logic move_dir_i,
	input wire logic single_ended_variant_i,
	input wire logic malfunction_i,
	input wire logic magnet_north_i,
	input wire logic magnet_south_i,
	// Link lines
	input wire logic quad_channel_a,
	input wire logic quad_channel_a_n,
	input wire logic quad_channel_b,
	input wire logic quad_channel_b_n,
	input wire logic ref_mark_pulse,
	input wire logic ref_mark_pulse_n,
	input wire logic fault_out_n,
	input wire logic [2:0] comm,
	input wire logic [2:0] comm_n,
	input wire logic limit_out_first,
	input wire logic limit_out_second
);
	import esqw_pkg::*;
	logic [FLT_W-1:0] low_cnt;
	logic [FLT_W-1:0] next_low_cnt;
	logic se;
	////////////////////////////////////////////////////////////////
	// Fault low time; saturates so it cannot wrap
	always_comb begin
		next_low_cnt = low_cnt;
		if (fault_out_n) begin
			next_low_cnt = '0;
		end else if (low_cnt != '1) begin
			next_low_cnt = low_cnt + 1'b1;
		end
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end
	assign se = single_ended_variant_i;
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_quad_one_edge: assert property (
		!($changed(quad_channel_a) && $changed(quad_channel_b))) else $error("A and B moved together");
	a_phase_order: assert property (
		$rose(quad_channel_a) && $past(move_dir_i) == $past(move_dir_i, 2)
		|-> quad_channel_b == $past(move_dir_i)) else $error("wrong phase order");
	a_ref_gated: assert property (ref_mark_pulse |-> quad_channel_a && quad_channel_b)
		else $error("reference outside its state");
	a_comp_lines: assert property (
		!se && !$past(se) && !$past(sys_rst_i) |-> quad_channel_a_n == !quad_channel_a
		&& quad_channel_b_n == !quad_channel_b && ref_mark_pulse_n == !ref_mark_pulse)
		else $error("complement wrong");
	a_single_low: assert property (
		se && $past(se) && !$past(sys_rst_i) |-> !quad_channel_a_n && !quad_channel_b_n
		&& !ref_mark_pulse_n) else $error("complement driven in single-ended");
	a_comm_comp: assert property (!$past(sys_rst_i) |-> comm_n == ~comm)
		else $error("commutation complement wrong");
	a_fault_low: assert property (malfunction_i |=> !fault_out_n)
		else $error("fault not reported");
	a_fault_hold: assert property ($rose(fault_out_n) |-> low_cnt >= FAULT_MIN_CYC - 1)
		else $error("fault pulse too short");
	a_limit_lines: assert property (
		!$past(sys_rst_i) |-> limit_out_first == $past(magnet_north_i)
		&& limit_out_second == $past(magnet_south_i))
		else $error("limit line wrong");
endmodule

// >>> encoder_square_wave_outputs_bench.sv
// Bench joining encoder and receiver through the link interface.
// Assumes both ends share one clock; a model decodes the link.
`timescale 1ns/1ps
module encoder_square_wave_outputs_bench;
	import esqw_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic move_en_i = 1'b0;
	logic move_dir_i = 1'b0;
	logic ref_here_i = 1'b0;
	logic single_ended_variant_i = 1'b0;
	logic malfunction_i = 1'b0;
	logic magnet_north_i = 1'b0;
	logic magnet_south_i = 1'b0;
	logic [DIV_W-1:0] step_div_i = '0;
	logic [ANG_W-1:0] angle_i = '0;
	logic [1:0] comm_mode_i = 2'h0;
	logic [1:0] eval_mode_i = 2'h0;
	logic [POS_W-1:0] position_o;
	logic ref_seen_o, fault_o, shutdown_o, step_err_o, limit_first_o, limit_second_o;
	logic [2:0] comm_o;
	int mismatches = 0;
	int compares = 0;
	int mpos = 0;
	logic mref = 1'b0;
	logic [1:0] prev_ab = 2'h0;
	esqw_if link_if ();
	esqw_encoder esqw_encoder_inst (.core_clk_i, .sys_rst_i, .move_en_i, .move_dir_i,
		.step_div_i, .ref_here_i, .angle_i, .comm_mode_i, .single_ended_variant_i,
		.malfunction_i, .magnet_north_i, .magnet_south_i, .link(link_if));
	esqw_receiver esqw_receiver_inst (.core_clk_i, .sys_rst_i, .eval_mode_i, .link(link_if),
		.position_o, .ref_seen_o, .fault_o, .shutdown_o, .step_err_o, .comm_o,
		.limit_first_o, .limit_second_o);
	esqw_link_asserts esqw_link_asserts_inst (.core_clk_i, .sys_rst_i, .move_dir_i,
		.single_ended_variant_i, .malfunction_i, .magnet_north_i, .magnet_south_i,
		.quad_channel_a(link_if.quad_channel_a), .quad_channel_a_n(link_if.quad_channel_a_n),
		.quad_channel_b(link_if.quad_channel_b), .quad_channel_b_n(link_if.quad_channel_b_n),
		.ref_mark_pulse(link_if.ref_mark_pulse), .ref_mark_pulse_n(link_if.ref_mark_pulse_n),
		.fault_out_n(link_if.fault_out_n), .comm(link_if.comm), .comm_n(link_if.comm_n),
		.limit_out_first(link_if.limit_out_first), .limit_out_second(link_if.limit_out_second));
	////////////////////////////////////////////////////////////////
	// Clock and watchdog; whole run needs about 2500 cycles
	always #25 core_clk_i = ~core_clk_i;
	initial begin
		#(50 * 10000);
		mismatches++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////
	// Gray order of {A,B} with A leading B in reference direction
	function automatic int gray_ord(input logic [1:0] s);
		return (s == 2'h0) ? 0 : (s == 2'h2) ? 1 : (s == 2'h3) ? 2 : 3;
	endfunction
	// Receiver model: forward steps count up
	always @(posedge core_clk_i) begin
		int d;
		d = (gray_ord({link_if.quad_channel_a, link_if.quad_channel_b}) - gray_ord(prev_ab)) & 3;
		if (sys_rst_i) begin
			mpos = 0;
			mref = 1'b0;
		end else begin
			if (eval_mode_i == EVAL_4X || (prev_ab[1] != link_if.quad_channel_a
				&& (eval_mode_i == EVAL_2X || !link_if.quad_channel_b))) begin
				mpos = mpos + ((d == 1) ? 1 : (d == 3) ? -1 : 0);
			end
			if (link_if.ref_mark_pulse === 1'b1) begin
				mref = 1'b1;
			end
		end
		prev_ab = {link_if.quad_channel_a, link_if.quad_channel_b};
	end
	////////////////////////////////////////////////////////////////
	task automatic cmp_pos(input logic [POS_W-1:0] got, input int exp);
		compares++;
		if (got !== POS_W'(exp)) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, POS_W'(exp));
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Each test: one eval and commutation mode (both t % 3), both directions
	initial begin
		void'($urandom(32'hAF844A6B));
		repeat (5) @(posedge core_clk_i);
		for (int t = 0; t < 6; t++) begin
			sys_rst_i <= 1'b1;
			eval_mode_i <= 2'(t % 3);
			comm_mode_i <= 2'(t % 3);
			single_ended_variant_i <= t[0];
			step_div_i <= DIV_W'(1 + $urandom_range(4));
			@(posedge core_clk_i);
			sys_rst_i <= 1'b0;
			for (int k = 0; k < 400; k++) begin
				@(posedge core_clk_i);
				move_en_i <= (k < 380);
				move_dir_i <= (k >= 150);
				malfunction_i <= (k == 100);
				if (k < 380) begin
					ref_here_i <= 1'($urandom_range(1));
					angle_i <= ANG_W'($urandom);
					magnet_north_i <= 1'($urandom_range(1));
					magnet_south_i <= 1'($urandom_range(1));
				end
			end
			#1;
			cmp_pos(position_o, mpos);
			cmp_bit(ref_seen_o, mref);
			cmp_bit(fault_o, 1'b1);
			cmp_bit(shutdown_o, 1'b1);
			cmp_bit(step_err_o, 1'b0);
			cmp_bit(limit_first_o, magnet_north_i);
			cmp_bit(limit_second_o, magnet_south_i);
			$display("test %0d done", t);
			@(posedge core_clk_i);
		end
		finish_test();
	end
endmodule
